// *** bench/hlem_slave_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ------------------------------
// Far-side instrument model
// ------------------------------
module hlem_slave_model (
  // Clock
  input  wire logic            core_clk,
  // Character stream
  output hlem_pkg::hlem_char_t rx_char,
  output logic                 rx_valid,
  output logic                 rx_eom,
  output logic [1:0]           rx_eom_port
);
  initial begin
    rx_valid = 1'b0;
    rx_eom = 1'b0;
    rx_eom_port = 2'h0;
    rx_char = '0;
  end
  // Even parity unless told to break it; stop bit high unless told
  task automatic put(input logic [1:0] p, input logic [7:0] d, input logic bp, input logic bs);
    @(posedge core_clk);
    rx_valid <= 1'b1;
    rx_eom <= 1'b0;
    rx_char <= '{port: p, data: d, par: (^d) ^ bp, stop: ~bs};
  endtask
  task automatic idle(input int n);
    repeat (n) begin
      @(posedge core_clk);
      rx_valid <= 1'b0;
      rx_eom <= 1'b0;
      rx_char <= ~rx_char; // Released line must not look like a held byte
    end
  endtask
  task automatic eom(input logic [1:0] p);
    @(posedge core_clk);
    rx_valid <= 1'b0;
    rx_eom <= 1'b1;
    rx_eom_port <= p;
    idle(3);
  endtask
endmodule
`default_nettype wire

// *** bench/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_mismatch++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb;
  localparam int BUFB = 8;
  logic                  core_clk, nrst, ce, hold;
  logic                  rx_valid, rx_eom, cmd_valid, poll_valid, out_valid, out_ready;
  logic [1:0]            rx_eom_port, rd_port;
  logic [2:0]            rd_idx;
  logic [15:0]           resp_timeout_ms, rd_data_r;
  hlem_pkg::hlem_char_t  rx_char;
  hlem_pkg::hlem_cmd_t   cmd;
  hlem_pkg::hlem_poll_t  poll;
  hlem_pkg::hlem_byte_t  out_byte, eb;
  hlem_pkg::hlem_slave_t slave_stat [4][16];
  hlem_pkg::hlem_byte_t  exp_q [$];
  logic [15:0]           exp_cnt [4][7];
  int                    n_mismatch, samples_checked;

  hlem_slave_model hlem_slave_model_inst (.core_clk(core_clk), .rx_char(rx_char),
    .rx_valid(rx_valid), .rx_eom(rx_eom), .rx_eom_port(rx_eom_port));
  // Short gap and tick counts keep the run brief
  hlem_monitor #(.GAP_CYC(40), .MS_CYC(8), .BUFB(BUFB)) hlem_monitor_inst (
    .core_clk(core_clk), .nrst(nrst), .ce(ce), .rx_valid(rx_valid), .rx_char(rx_char),
    .rx_eom(rx_eom), .rx_eom_port(rx_eom_port), .cmd_valid(cmd_valid), .cmd(cmd),
    .resp_timeout_ms(resp_timeout_ms), .poll_valid(poll_valid), .poll(poll),
    .out_valid(out_valid), .out_ready(out_ready), .out_byte(out_byte), .rd_port(rd_port),
    .rd_idx(rd_idx), .rd_data_r(rd_data_r), .slave_stat_r(slave_stat));

  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  initial begin
    #2000000;
    n_mismatch++;
    wrap_up();
  end
  // ------------------------------
  // Output watcher
  // ------------------------------
  always @(posedge core_clk) out_ready <= hold ? 1'b0 : ($urandom_range(0, 3) != 0);
  always @(posedge core_clk) begin
    if (nrst && ce && out_valid && out_ready) begin
      `CHK(exp_q.size() != 0, 1'b1)
      if (exp_q.size() != 0) begin
        eb = exp_q.pop_front();
        `CHK(out_byte, eb)
      end
    end
  end
  // ------------------------------
  // Tasks
  // ------------------------------
  task automatic wrap_up();
    $display("mismatches=%0d checks=%0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic snd(input logic [1:0] p, input logic [7:0] d, input logic bp,
                     input logic bs, input logic keep);
    hlem_slave_model_inst.put(p, d, bp, bs);
    if (keep) exp_q.push_back('{port: p, data: d});
  endtask
  task automatic msg(input logic [1:0] p, input int npre, input int nbody, input logic bad);
    logic [7:0] x, d;
    x = 8'h00;
    repeat (npre) snd(p, 8'hff, 1'b0, 1'b0, 1'b1);
    for (int i = 0; i < nbody; i++) begin
      d = 8'($urandom_range(0, 254));
      x ^= d;
      snd(p, d, 1'b0, 1'b0, 1'b1);
    end
    snd(p, x ^ {7'h00, bad}, 1'b0, 1'b0, 1'b1);
    hlem_slave_model_inst.eom(p);
  endtask
  task automatic chk_port(input logic [1:0] p);
    for (int i = 0; i < 8; i++) begin
      @(posedge core_clk);
      rd_port <= p;
      rd_idx <= 3'(i);
      repeat (2) @(posedge core_clk);
      #1;
      `CHK(rd_data_r, (i < 7) ? exp_cnt[p][i] : 16'h0000)
    end
  endtask
  task automatic drain();
    int n;
    n = 0;
    while ((exp_q.size() != 0 || out_valid) && n < 300) begin
      @(posedge core_clk);
      n++;
    end
    if (n == 300) begin
      n_mismatch++;
      wrap_up();
    end
  endtask
  task automatic cmd_do(input logic [1:0] p, input hlem_pkg::hlem_cmd_kind_t k);
    @(posedge core_clk);
    cmd_valid <= 1'b1;
    cmd <= '{port: p, kind: k};
    @(posedge core_clk);
    cmd_valid <= 1'b0;
  endtask
  task automatic poll_do(input logic [1:0] p, input logic [3:0] a, input logic ok);
    @(posedge core_clk);
    poll_valid <= 1'b1;
    poll <= '{port: p, addr: a, ok: ok};
    @(posedge core_clk);
    poll_valid <= 1'b0;
  endtask
  // ------------------------------
  // Main sequence
  // ------------------------------
  initial begin
    void'($urandom(15));
    nrst = 1'b0;
    ce = 1'b1;
    hold = 1'b0;
    out_ready = 1'b0;
    cmd_valid = 1'b0;
    poll_valid = 1'b0;
    cmd = '0;
    poll = '0;
    rd_port = 2'h0;
    rd_idx = 3'h0;
    resp_timeout_ms = 16'h0002;
    foreach (exp_cnt[i, j]) exp_cnt[i][j] = 16'h0000;
    repeat (8) @(posedge core_clk);
    nrst <= 1'b1;
    foreach (slave_stat[i, j]) `CHK(slave_stat[i][j], hlem_pkg::HLEM_SL_NONE)
    for (int p = 0; p < 4; p++) chk_port(2'(p));
    // Enable low: a broken byte must be neither counted nor buffered
    @(posedge core_clk);
    ce <= 1'b0;
    snd(2'h0, 8'h00, 1'b1, 1'b1, 1'b0);
    hlem_slave_model_inst.idle(1);
    ce <= 1'b1;
    chk_port(2'h0);
    msg(2'h0, 3, 4, 1'b0);
    msg(2'h0, 3, 5, 1'b1);
    exp_cnt[0][4]++;
    chk_port(2'h0);
    msg(2'h2, 2, 3, 1'b0);
    exp_cnt[2][2]++;
    chk_port(2'h2);
    msg(2'h1, 3, BUFB - 1, 1'b0);
    msg(2'h1, 3, BUFB + 1, 1'b0);
    exp_cnt[1][1]++;
    chk_port(2'h1);
    // Idle just over the limit ends the message, just under does not
    repeat (3) snd(2'h1, 8'hff, 1'b0, 1'b0, 1'b1);
    snd(2'h1, 8'h12, 1'b0, 1'b0, 1'b1);
    hlem_slave_model_inst.idle(50);
    hlem_slave_model_inst.eom(2'h1);
    exp_cnt[1][0]++;
    repeat (3) snd(2'h1, 8'hff, 1'b0, 1'b0, 1'b1);
    snd(2'h1, 8'h12, 1'b0, 1'b0, 1'b1);
    hlem_slave_model_inst.idle(30);
    snd(2'h1, 8'h12, 1'b0, 1'b0, 1'b1);
    hlem_slave_model_inst.eom(2'h1);
    chk_port(2'h1);
    repeat (3) snd(2'h2, 8'hff, 1'b0, 1'b0, 1'b1);
    snd(2'h2, 8'hff, 1'b1, 1'b0, 1'b1);
    snd(2'h2, 8'hff, 1'b0, 1'b1, 1'b1);
    snd(2'h2, 8'hff, 1'b1, 1'b1, 1'b1);
    hlem_slave_model_inst.eom(2'h2);
    exp_cnt[2][5] += 16'h0004;
    chk_port(2'h2);
    drain();
    @(posedge core_clk);
    hold <= 1'b1;
    repeat (2) @(posedge core_clk);
    repeat (16) snd(2'h3, 8'hff, 1'b0, 1'b0, 1'b1);
    snd(2'h3, 8'hff, 1'b0, 1'b0, 1'b0);
    hlem_slave_model_inst.eom(2'h3);
    exp_cnt[3][5]++;
    hold <= 1'b0;
    drain();
    chk_port(2'h3);
    cmd_do(2'h0, hlem_pkg::HLEM_CMD_ISSUE);
    cmd_do(2'h0, hlem_pkg::HLEM_CMD_RETRY);
    cmd_do(2'h0, hlem_pkg::HLEM_CMD_REPLY);
    exp_cnt[0][3]++;
    chk_port(2'h0);
    resp_timeout_ms <= 16'h0004;
    cmd_do(2'h1, hlem_pkg::HLEM_CMD_ISSUE);
    repeat (40) @(posedge core_clk);
    exp_cnt[1][6]++;
    chk_port(2'h1);
    poll_do(2'h1, 4'h5, 1'b1);
    poll_do(2'h2, 4'hf, 1'b0);
    repeat (2) @(posedge core_clk);
    `CHK(slave_stat[1][5], hlem_pkg::HLEM_SL_OK)
    `CHK(slave_stat[2][15], hlem_pkg::HLEM_SL_ERR)
    `CHK(slave_stat[1][4], hlem_pkg::HLEM_SL_NONE)
    drain();
    for (int p = 0; p < 4; p++) chk_port(2'(p));
    wrap_up();
  end
endmodule
`default_nettype wire

// *** src/hlem_fifo.sv ***
`timescale 1ns/1ps
`default_nettype none
module hlem_fifo #(
  parameter int W = 10,
  parameter int D = 16
) (
  // Clock, reset and enable
  input  wire logic         core_clk,
  input  wire logic         nrst,
  input  wire logic         ce,
  // Fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // Drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(D);

  logic [W-1:0] mem_r [D];
  logic [AW-1:0] wr_r;
  logic [AW-1:0] rd_r;
  logic [AW:0]   cnt_r;
  logic          push;
  logic          pop;

  assign in_ready  = (cnt_r != (AW+1)'(D));
  assign out_valid = (cnt_r != '0);
  assign out_data  = mem_r[rd_r];
  assign push      = ce && in_valid && in_ready;
  assign pop       = ce && out_valid && out_ready;

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem_r[wr_r] <= in_data;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      wr_r  <= '0;
      rd_r  <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wr_r <= (wr_r == AW'(D-1)) ? '0 : wr_r + 1'b1;
      end
      if (pop) begin
        rd_r <= (rd_r == AW'(D-1)) ? '0 : rd_r + 1'b1;
      end
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule
`default_nettype wire

// *** src/hlem_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "hlem_regs.svh"
module hlem_monitor #(
  parameter int NPORTS  = 4,
  parameter int NSLAVE  = 16,
  parameter int CW      = 16,
  parameter int BUFB    = `HLEM_BUF_BYTES,
  parameter int GAP_CYC = `HLEM_GAP_MS * `HLEM_US_PER_MS * `HLEM_CLK_MHZ,
  parameter int MS_CYC  = `HLEM_US_PER_MS * `HLEM_CLK_MHZ
) (
  // Clock, reset, enable
  input  wire logic                 core_clk,
  input  wire logic                 nrst,
  input  wire logic                 ce,
  // Received characters
  input  wire logic                 rx_valid,
  input  wire hlem_pkg::hlem_char_t rx_char,
  input  wire logic                 rx_eom,
  input  wire logic [1:0]           rx_eom_port,
  // Command events
  input  wire logic                 cmd_valid,
  input  wire hlem_pkg::hlem_cmd_t  cmd,
  input  wire logic [15:0]          resp_timeout_ms,
  // Poll results
  input  wire logic                 poll_valid,
  input  wire hlem_pkg::hlem_poll_t poll,
  // Byte stream out
  output logic                      out_valid,
  input  wire logic                 out_ready,
  output hlem_pkg::hlem_byte_t      out_byte,
  // Counter and slave status readout
  input  wire logic [1:0]           rd_port,
  input  wire logic [2:0]           rd_idx,
  output logic [CW-1:0]             rd_data_r,
  output hlem_pkg::hlem_slave_t     slave_stat_r [NPORTS][NSLAVE]
);
  localparam int GW = $clog2(GAP_CYC + 1);
  localparam int MW = $clog2(MS_CYC);

  hlem_pkg::hlem_parse_t par_r   [NPORTS];
  hlem_pkg::hlem_parse_t par_nxt [NPORTS];
  logic [GW-1:0]  gap_r   [NPORTS];
  logic [GW-1:0]  gap_nxt [NPORTS];
  logic           wait_r   [NPORTS];
  logic           wait_nxt [NPORTS];
  logic [15:0]    tmr_r    [NPORTS];
  logic [15:0]    tmr_nxt  [NPORTS];
  logic [1:0]     inc      [NPORTS][`HLEM_NCNT];
  logic [CW-1:0]  cnt_r    [NPORTS][`HLEM_NCNT];
  logic [MW-1:0]  ms_r;
  logic           ms_tick;
  logic           fifo_in_ready;
  logic           byte_here;
  logic           active;
  hlem_pkg::hlem_byte_t fifo_in;

  // ---------------------------------------------------------------
  // Receive buffer
  // ---------------------------------------------------------------
  assign fifo_in = '{port: rx_char.port, data: rx_char.data};

  hlem_fifo #(
    .W ($bits(hlem_pkg::hlem_byte_t)),
    .D (`HLEM_FIFO_DEPTH)
  ) u_fifo (
    .core_clk  (core_clk),
    .nrst      (nrst),
    .ce        (ce),
    .in_valid  (rx_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (fifo_in),
    .out_valid (out_valid),
    .out_ready (out_ready),
    .out_data  (out_byte)
  );

  // ---------------------------------------------------------------
  // Millisecond tick for response timeouts
  // ---------------------------------------------------------------
  assign ms_tick = (ms_r == MW'(MS_CYC - 1));

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ms_r <= '0;
    end else if (ce) begin
      ms_r <= ms_tick ? '0 : ms_r + 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Per-port message parse and command tracking
  // ---------------------------------------------------------------
  always_comb begin
    byte_here = 1'b0;
    active    = 1'b0;
    for (int p = 0; p < NPORTS; p++) begin
      par_nxt[p]  = par_r[p];
      gap_nxt[p]  = gap_r[p];
      wait_nxt[p] = wait_r[p];
      tmr_nxt[p]  = tmr_r[p];
      for (int k = 0; k < `HLEM_NCNT; k++) begin
        inc[p][k] = 2'h0;
      end
      active    = par_r[p].in_msg || (par_r[p].pre != 2'h0);
      byte_here = rx_valid && fifo_in_ready && (rx_char.port == 2'(p));
      if (rx_valid && (rx_char.port == 2'(p))) begin
        // Overrun, parity, framing summed per occurrence
        inc[p][`HLEM_CNT_OPF] = 2'(!rx_char.stop)
                              + 2'(^{rx_char.data, rx_char.par})
                              + 2'(!fifo_in_ready);
      end
      if (byte_here) begin
        gap_nxt[p] = '0;
        if (!par_r[p].in_msg) begin
          if (rx_char.data == `HLEM_PREAMBLE_CHAR) begin
            if (par_r[p].pre != `HLEM_MIN_PREAMBLE) begin
              par_nxt[p].pre = par_r[p].pre + 2'h1;
            end
          end else begin
            if (par_r[p].pre < `HLEM_MIN_PREAMBLE) begin
              inc[p][`HLEM_CNT_SOM] = 2'h1;
            end
            par_nxt[p] = '{in_msg: 1'b1, pre: 2'h0, bcnt: 8'h01,
                           csum: rx_char.data, ovf: 1'b0};
          end
        end else begin
          par_nxt[p].csum = par_r[p].csum ^ rx_char.data;
          if (par_r[p].bcnt == 8'(BUFB)) begin
            if (!par_r[p].ovf) begin
              inc[p][`HLEM_CNT_OVF] = 2'h1;
            end
            par_nxt[p].ovf = 1'b1;
          end else begin
            par_nxt[p].bcnt = par_r[p].bcnt + 8'h01;
          end
        end
      end else if (active) begin
        if (gap_r[p] == GW'(GAP_CYC)) begin
          // Message abandoned so one gap counts once
          inc[p][`HLEM_CNT_GAP] = 2'h1;
          par_nxt[p] = '0;
          gap_nxt[p] = '0;
        end else begin
          gap_nxt[p] = gap_r[p] + 1'b1;
        end
      end else begin
        gap_nxt[p] = '0;
      end
      if (rx_eom && (rx_eom_port == 2'(p))) begin
        if (par_nxt[p].in_msg && (par_nxt[p].csum != 8'h00)) begin
          inc[p][`HLEM_CNT_CHK] = 2'h1;
        end
        par_nxt[p] = '0;
        gap_nxt[p] = '0;
      end
      if (wait_r[p] && ms_tick) begin
        if (tmr_r[p] + 16'h0001 >= resp_timeout_ms) begin
          inc[p][`HLEM_CNT_TMO] = 2'h1;
          wait_nxt[p] = 1'b0;
        end else begin
          tmr_nxt[p] = tmr_r[p] + 16'h0001;
        end
      end
      if (cmd_valid && (cmd.port == 2'(p))) begin
        case (cmd.kind)
          hlem_pkg::HLEM_CMD_RETRY: begin
            inc[p][`HLEM_CNT_RETRY] = 2'h1;
            wait_nxt[p] = 1'b1;
            tmr_nxt[p]  = 16'h0000;
          end
          hlem_pkg::HLEM_CMD_REPLY: begin
            wait_nxt[p] = 1'b0;
          end
          default: begin
            wait_nxt[p] = 1'b1;
            tmr_nxt[p]  = 16'h0000;
          end
        endcase
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      for (int p = 0; p < NPORTS; p++) begin
        par_r[p]  <= '0;
        gap_r[p]  <= '0;
        wait_r[p] <= 1'b0;
        tmr_r[p]  <= '0;
      end
    end else if (ce) begin
      par_r  <= par_nxt;
      gap_r  <= gap_nxt;
      wait_r <= wait_nxt;
      tmr_r  <= tmr_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Error counters
  // ---------------------------------------------------------------
  // Wrap rather than saturate; software takes differences
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      for (int p = 0; p < NPORTS; p++) begin
        for (int k = 0; k < `HLEM_NCNT; k++) begin
          cnt_r[p][k] <= '0;
        end
      end
    end else if (ce) begin
      for (int p = 0; p < NPORTS; p++) begin
        for (int k = 0; k < `HLEM_NCNT; k++) begin
          cnt_r[p][k] <= cnt_r[p][k] + CW'(inc[p][k]);
        end
      end
    end
  end

  // Readout is a plain copy, never touching the counters
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rd_data_r <= '0;
    end else if (ce) begin
      if ((int'(rd_port) < NPORTS) && (rd_idx < 3'(`HLEM_NCNT))) begin
        rd_data_r <= cnt_r[rd_port][rd_idx];
      end else begin
        rd_data_r <= '0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Slave status
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      for (int p = 0; p < NPORTS; p++) begin
        for (int s = 0; s < NSLAVE; s++) begin
          slave_stat_r[p][s] <= hlem_pkg::HLEM_SL_NONE;
        end
      end
    end else if (ce && poll_valid && (int'(poll.port) < NPORTS)
                 && (int'(poll.addr) < NSLAVE)) begin
      slave_stat_r[poll.port][poll.addr] <= poll.ok ? hlem_pkg::HLEM_SL_OK
                                                    : hlem_pkg::HLEM_SL_ERR;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  a_gap_count: assert property (ce && par_r[1].in_msg && !(rx_valid && rx_char.port == 2'h1)
    && !rx_eom && gap_r[1] == GW'(GAP_CYC) |=> !par_r[1].in_msg
    && cnt_r[1][`HLEM_CNT_GAP] == $past(cnt_r[1][`HLEM_CNT_GAP]) + 1'b1)
    else $error("gap error not counted");
  a_ovf_bound: assert property (par_r[0].bcnt <= 8'(BUFB))
    else $error("byte count past buffer size");
  a_som_short: assert property (ce && rx_valid && fifo_in_ready && rx_char.port == 2'h2
    && !par_r[2].in_msg
    && rx_char.data != `HLEM_PREAMBLE_CHAR && par_r[2].pre < `HLEM_MIN_PREAMBLE
    |=> cnt_r[2][`HLEM_CNT_SOM] == $past(cnt_r[2][`HLEM_CNT_SOM]) + 1'b1)
    else $error("short preamble not counted");
  a_retry_count: assert property (ce && cmd_valid && cmd.port == 2'h0
    && cmd.kind == hlem_pkg::HLEM_CMD_RETRY
    |=> cnt_r[0][`HLEM_CNT_RETRY] != $past(cnt_r[0][`HLEM_CNT_RETRY]) && wait_r[0])
    else $error("retry not counted");
  a_chk_count: assert property (ce && rx_eom && rx_eom_port == 2'h0 && !rx_valid
    && par_r[0].in_msg && par_r[0].csum != 8'h00
    |=> cnt_r[0][`HLEM_CNT_CHK] == $past(cnt_r[0][`HLEM_CNT_CHK]) + 1'b1)
    else $error("checksum error not counted");
  a_overrun_lost: assert property (ce && rx_valid && !fifo_in_ready && rx_char.port == 2'h3
    |=> cnt_r[3][`HLEM_CNT_OPF] != $past(cnt_r[3][`HLEM_CNT_OPF]))
    else $error("overrun not counted");
  a_parity_flag: assert property (ce && rx_valid && rx_char.port == 2'h2
    && ^{rx_char.data, rx_char.par} |=> cnt_r[2][`HLEM_CNT_OPF] != $past(cnt_r[2][`HLEM_CNT_OPF]))
    else $error("parity error not counted");
  a_frame_flag: assert property (ce && rx_valid && rx_char.port == 2'h2 && !rx_char.stop
    |=> cnt_r[2][`HLEM_CNT_OPF] != $past(cnt_r[2][`HLEM_CNT_OPF]))
    else $error("framing error not counted");
  a_tmo_count: assert property (ce && wait_r[1] && ms_tick && !cmd_valid
    && tmr_r[1] + 16'h0001 >= resp_timeout_ms
    |=> !wait_r[1] && cnt_r[1][`HLEM_CNT_TMO] == $past(cnt_r[1][`HLEM_CNT_TMO]) + 1'b1)
    else $error("response timeout not counted");
  a_slave_state: assert property (ce && poll_valid && poll.port == 2'h1 && poll.ok
    |=> slave_stat_r[1][$past(poll.addr)] == hlem_pkg::HLEM_SL_OK)
    else $error("slave status not updated");
  a_read_copy: assert property (ce && rd_port == 2'h0 && rd_idx == 3'h0
    |=> rd_data_r == $past(cnt_r[0][0]))
    else $error("readout mismatch");

  c_overflow: cover property (inc[0][`HLEM_CNT_OVF] != 2'h0);
  c_timeout:  cover property (inc[0][`HLEM_CNT_TMO] != 2'h0);
  c_fifo_full: cover property (rx_valid && !fifo_in_ready);
  c_good_msg: cover property (rx_eom && par_r[0].in_msg && par_r[0].csum == 8'h00);
endmodule
`default_nettype wire

// *** src/hlem_pkg.sv ***
package hlem_pkg;
  typedef enum logic [1:0] {HLEM_SL_NONE, HLEM_SL_OK, HLEM_SL_ERR} hlem_slave_t;
  typedef enum logic [1:0] {HLEM_CMD_ISSUE, HLEM_CMD_RETRY, HLEM_CMD_REPLY} hlem_cmd_kind_t;
  typedef struct packed {
    logic [1:0] port;
    logic [7:0] data;
    logic       par;
    logic       stop;
  } hlem_char_t;
  typedef struct packed {
    logic [1:0] port;
    logic [7:0] data;
  } hlem_byte_t;
  typedef struct packed {
    logic [1:0]     port;
    hlem_cmd_kind_t kind;
  } hlem_cmd_t;
  typedef struct packed {
    logic [1:0] port;
    logic [3:0] addr;
    logic       ok;
  } hlem_poll_t;
  typedef struct packed {
    logic       in_msg;
    logic [1:0] pre;
    logic [7:0] bcnt;
    logic [7:0] csum;
    logic       ovf;
  } hlem_parse_t;
endpackage

// *** src/hlem_regs.svh ***
`ifndef HLEM_REGS_SVH
`define HLEM_REGS_SVH
// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define HLEM_CLK_MHZ        50
`define HLEM_US_PER_MS      1000
`define HLEM_GAP_MS         20
// ---------------------------------------------------------------
// Framing
// ---------------------------------------------------------------
`define HLEM_MIN_PREAMBLE   2'h3
`define HLEM_PREAMBLE_CHAR  8'hff
`define HLEM_BUF_BYTES      64
`define HLEM_FIFO_DEPTH     16
// ---------------------------------------------------------------
// Counter indices
// ---------------------------------------------------------------
`define HLEM_CNT_GAP        0
`define HLEM_CNT_OVF        1
`define HLEM_CNT_SOM        2
`define HLEM_CNT_RETRY      3
`define HLEM_CNT_CHK        4
`define HLEM_CNT_OPF        5
`define HLEM_CNT_TMO        6
`define HLEM_NCNT           7
`endif
